// ===== hw/pcl_defs.svh
// Register offsets, field positions, reset values and timing counts of the loop clock block.
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

`define PCL_ADDR_W          8
`define PCL_ADDR_DIV_LO     8'h5C
`define PCL_ADDR_DIV_HI     8'h5D
`define PCL_ADDR_CTL0       8'h5E
`define PCL_ADDR_CTL1       8'h5F
`define PCL_ADDR_STAT       8'h60
`define PCL_ADDR_MASK       8'h61

`define PCL_DIV_W           11
`define PCL_DIV_LO_RST      8'h02
`define PCL_DIV_HI_RST      3'h0
`define PCL_DIV_MIN         11'h002

`define PCL_CTL0_PUMP_HI    7
`define PCL_CTL0_PUMP_LO    6
`define PCL_CTL0_CRIT_HI    3
`define PCL_CTL0_CRIT_LO    2
`define PCL_CTL0_SRC_HI     1
`define PCL_CTL0_SRC_LO     0
`define PCL_CTL0_RST        8'h00
`define PCL_CTL1_EN_BIT     0
`define PCL_CTL1_LOCK_BIT   1

`define PCL_SRC_CODE_CRYSTAL_REFERENCE   2'b00
`define PCL_SRC_CODE_LOOP   2'b01
`define PCL_SRC_CODE_RTC    2'b10
`define PCL_SRC_CODE_KEEP   2'b11

`define PCL_EVT_LOCK        0
`define PCL_EVT_UNLOCK      1
`define PCL_EVT_W           2

`define PCL_CLK_NS          50
`define PCL_CRIT_FINE_NS    20
`define PCL_CRIT_COARSE_NS  400
`define PCL_CRIT_FINE_CYC   (((`PCL_CRIT_FINE_NS / `PCL_CLK_NS) < 1) ? 1 : (`PCL_CRIT_FINE_NS / `PCL_CLK_NS))
`define PCL_CRIT_COARSE_CYC (((`PCL_CRIT_COARSE_NS / `PCL_CLK_NS) < 1) ? 1 : (`PCL_CRIT_COARSE_NS / `PCL_CLK_NS))
`define PCL_LOCK_RUN_SHORT  5'd8
`define PCL_LOCK_RUN_LONG   5'd16

`endif

// ===== hw/pcl_divider.sv
// Programmable feedback downcounter that divides the oscillator by the loop factor.
`timescale 1ns/1ps
`include "pcl_defs.svh"
module pcl_divider (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Oscillator level
    input  wire logic osc_in,
    // Loop signals
    pcl_loop_if.div   lp
);
    import pcl_pkg::*;

    logic     osc_q;
    pcl_div_t cnt_q;
    logic     lvl_q;
    logic     fall_q;
    wire      osc_rise = osc_in & ~osc_q;
    wire      cnt_end  = (cnt_q <= 11'd1);
    // Output is high during the upper half of the count, so one period spans N edges.
    wire      lvl_d    = (cnt_q > {1'b0, lp.div_n[10:1]});

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !lp.enable) begin
            // Starting high keeps an oscillator that is already high from counting as a rise.
            osc_q  <= 1'b1;
            cnt_q  <= `PCL_DIV_MIN;
            lvl_q  <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            osc_q  <= osc_in;
            if (osc_rise) begin
                cnt_q <= cnt_end ? lp.div_n : cnt_q - 11'd1;
            end
            lvl_q  <= lvl_d;
            fall_q <= lvl_q & ~lvl_d;
        end
    end

    assign lp.div_level = lvl_q;
    assign lp.div_fall  = fall_q;
endmodule // pcl_divider

// ===== hw/pcl_lock_detect.sv
// Lock detector: counts consecutive reference periods whose phase error stays inside the window.
`timescale 1ns/1ps
`include "pcl_defs.svh"
module pcl_lock_detect (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Loop signals
    pcl_loop_if.det   lp
);
    import pcl_pkg::*;

    logic [4:0] err_cnt_q;
    logic       bad_q;
    logic [4:0] run_q;
    logic       lock_q;

    wire  [4:0] win_cyc  = lp.crit[1] ? 5'(`PCL_CRIT_COARSE_CYC)
                                      : 5'(`PCL_CRIT_FINE_CYC);
    wire  [4:0] need_run = lp.crit[0] ? `PCL_LOCK_RUN_LONG
                                      : `PCL_LOCK_RUN_SHORT;
    wire  [4:0] err_next = lp.err_active ? err_cnt_q + 5'd1 : 5'd0;
    wire        too_long = (err_next >= win_cyc);
    wire        bad_now  = bad_q | too_long;
    wire  [4:0] run_next = run_q + 5'd1;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !lp.enable) begin
            err_cnt_q <= 5'd0;
            bad_q     <= 1'b0;
            run_q     <= 5'd0;
            lock_q    <= 1'b0;
        end else begin
            err_cnt_q <= (err_next == 5'd31) ? err_cnt_q : err_next;
            if (lp.ref_fall) begin
                bad_q <= 1'b0;
                if (bad_now) begin
                    run_q  <= 5'd0;
                    lock_q <= 1'b0;
                end else begin
                    run_q  <= (run_next >= need_run) ? run_q : run_next;
                    lock_q <= lock_q | (run_next >= need_run);
                end
            end else begin
                bad_q <= bad_now;
            end
        end
    end

    assign lp.lock = lock_q;
endmodule // pcl_lock_detect

// ===== hw/pcl_loop_if.sv
// Signals shared between the loop control top, the feedback divider and the lock detector.
`timescale 1ns/1ps
interface pcl_loop_if;
    import pcl_pkg::*;
    logic      enable;
    pcl_div_t  div_n;
    logic      div_level;
    logic      div_fall;
    logic      ref_fall;
    logic      err_active;
    pcl_crit_t crit;
    logic      lock;
    modport ctrl (output enable, output div_n, input div_level, input div_fall,
                  output ref_fall, output err_active, output crit, input lock);
    modport div  (input enable, input div_n, output div_level, output div_fall);
    modport det  (input enable, input ref_fall, input err_active, input crit, output lock);
endinterface

// ===== hw/pcl_pkg.sv
// Types shared by the loop clock block.
package pcl_pkg;
    typedef enum logic [2:0] {
        PCL_SRC_CRYSTAL_REFERENCE = 3'b001,
        PCL_SRC_LOOP = 3'b010,
        PCL_SRC_RTC  = 3'b100
    } pcl_src_e;
    typedef logic [10:0] pcl_div_t;
    typedef logic [1:0]  pcl_crit_t;
endpackage

// ===== hw/pcl_top.sv
// Loop clock control: registers, phase detector, pump control, lock sync, interrupt and clock mux.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "pcl_defs.svh"

// Summary of operation
// - Loop settles at N times the reference, N set by the divider registers.
// - Phase detector compares reference and divider falling edges, drives up/down errors.
// - Control bits 7:6 pick one of four pump currents, 100uA to 1.5mA.
// - With no phase error both pump commands stay low.
// - Feedback divider is a downcounter on oscillator edges dividing by N.
// - Software chooses the system clock between loop output, crystal reference and RTC reference.
// - Loop output becomes the system clock only once lock is reported.
// - Lock needs error under the window for the set count of reference periods.
// - Lock criterion comes from a software field in control register zero.
// - Lock drives a high lock signal that raises an interrupt request.
// - After reset the loop is off and the crystal feeds the system clock.
// - Criterion codes: 8 or 16 periods within 20 ns (rounded up to one 50 ns cycle) or 400 ns.
// - Whole 11-bit divider loads when the high byte is written while the loop is off, low byte first.
// - Divider values below two are replaced by two.
module pcl_top (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Register port
    input  wire logic [`PCL_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // Clock source levels
    input  wire logic                    crystal_reference,
    input  wire logic                    osc_in,
    input  wire logic                    rtc_ref,
    // Analog controls
    output logic                         loop_enable,
    output logic      [1:0]              pump_strength,
    output logic                         pump_up,
    output logic                         pump_dn,
    // System clock
    output logic                         sclk_out,
    output pcl_pkg::pcl_src_e            sclk_src,
    // Interrupt
    output logic                         irq
);
    import pcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0]             div_lo_q;
    pcl_div_t               div_n_q;
    logic [1:0]             pump_q;
    pcl_crit_t              crit_q;
    logic [1:0]             src_req_q;
    logic                   en_q;
    logic [`PCL_EVT_W-1:0]  stat_q;
    logic [`PCL_EVT_W-1:0]  mask_q;
    logic [7:0]             rdata_q;

    pcl_loop_if lp ();

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire hit_div_lo = (reg_addr == `PCL_ADDR_DIV_LO);
    wire hit_div_hi = (reg_addr == `PCL_ADDR_DIV_HI);
    wire hit_ctl0   = (reg_addr == `PCL_ADDR_CTL0);
    wire hit_ctl1   = (reg_addr == `PCL_ADDR_CTL1);
    wire hit_stat   = (reg_addr == `PCL_ADDR_STAT);
    wire hit_mask   = (reg_addr == `PCL_ADDR_MASK);

    wire wr_div_lo  = reg_wr & hit_div_lo & ~en_q;
    wire wr_div_hi  = reg_wr & hit_div_hi & ~en_q;
    // Pump and criterion fields may only change while the loop is off.
    wire wr_ctl0_lk = reg_wr & hit_ctl0 & ~en_q;
    wire wr_ctl0    = reg_wr & hit_ctl0;
    wire wr_ctl1    = reg_wr & hit_ctl1;
    wire wr_mask    = reg_wr & hit_mask;
    wire rd_stat    = reg_rd & hit_stat;

    wire pcl_div_t div_raw  = {reg_wdata[2:0], div_lo_q};
    wire pcl_div_t div_load = (div_raw < `PCL_DIV_MIN) ? `PCL_DIV_MIN : div_raw;
    wire [1:0]     src_wr   = reg_wdata[`PCL_CTL0_SRC_HI:`PCL_CTL0_SRC_LO];
    // Code 11 keeps the previous selection.
    wire           src_take = wr_ctl0 & (src_wr != `PCL_SRC_CODE_KEEP);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div_lo_q <= `PCL_DIV_LO_RST;
            div_n_q  <= {`PCL_DIV_HI_RST, `PCL_DIV_LO_RST};
        end else begin
            if (wr_div_lo) begin
                div_lo_q <= reg_wdata;
            end
            if (wr_div_hi) begin
                div_n_q <= div_load;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pump_q    <= 2'(`PCL_CTL0_RST >> `PCL_CTL0_PUMP_LO);
            crit_q    <= 2'(`PCL_CTL0_RST >> `PCL_CTL0_CRIT_LO);
            src_req_q <= `PCL_SRC_CODE_CRYSTAL_REFERENCE;
            en_q      <= 1'b0;
            mask_q    <= '0;
        end else begin
            if (wr_ctl0_lk) begin
                pump_q <= reg_wdata[`PCL_CTL0_PUMP_HI:`PCL_CTL0_PUMP_LO];
                crit_q <= reg_wdata[`PCL_CTL0_CRIT_HI:`PCL_CTL0_CRIT_LO];
            end
            if (src_take) begin
                src_req_q <= src_wr;
            end
            if (wr_ctl1) begin
                en_q <= reg_wdata[`PCL_CTL1_EN_BIT];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[`PCL_EVT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase detector on falling edges of reference and divided oscillator

    logic ref_q;
    logic up_q;
    logic dn_q;
    wire  ref_fall = ref_q & ~crystal_reference;
    wire  div_fall = lp.div_fall;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !en_q) begin
            ref_q <= 1'b0;
            up_q  <= 1'b0;
            dn_q  <= 1'b0;
        end else begin
            ref_q <= crystal_reference;
            if (ref_fall && div_fall) begin
                up_q <= 1'b0;
                dn_q <= 1'b0;
            end else if (ref_fall) begin
                up_q <= ~dn_q;
                dn_q <= 1'b0;
            end else if (div_fall) begin
                dn_q <= ~up_q;
                up_q <= 1'b0;
            end
        end
    end

    assign lp.enable     = en_q;
    assign lp.div_n      = div_n_q;
    assign lp.ref_fall   = ref_fall;
    assign lp.err_active = up_q | dn_q;
    assign lp.crit       = crit_q;

    pcl_divider u_div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .osc_in  (osc_in),
        .lp      (lp.div)
    );

    pcl_lock_detect u_lock (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .lp      (lp.det)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lock synchroniser and interrupt events

    logic lock_meta_q;
    logic lock_sync_q;
    logic lock_prev_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lock_meta_q <= 1'b0;
            lock_sync_q <= 1'b0;
            lock_prev_q <= 1'b0;
        end else begin
            lock_meta_q <= lp.lock;
            lock_sync_q <= lock_meta_q;
            lock_prev_q <= lock_sync_q;
        end
    end

    wire [`PCL_EVT_W-1:0] evt;
    assign evt[`PCL_EVT_LOCK]   = lock_sync_q & ~lock_prev_q;
    assign evt[`PCL_EVT_UNLOCK] = ~lock_sync_q & lock_prev_q;

    // A read clears the sticky bits, but an event in the same cycle survives it.
    genvar gi;
    generate
        for (gi = 0; gi < `PCL_EVT_W; gi = gi + 1) begin : g_evt
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    stat_q[gi] <= 1'b0;
                end else begin
                    stat_q[gi] <= evt[gi] | (stat_q[gi] & ~rd_stat);
                end
            end
        end
    endgenerate

    assign irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and glitch-free switch

    pcl_src_e src_q;
    logic     sclk_q;
    logic     want_loop;
    pcl_src_e want_src;

    assign want_loop = (src_req_q == `PCL_SRC_CODE_LOOP) & en_q & lock_sync_q;
    assign want_src  = want_loop ? PCL_SRC_LOOP :
                       (src_req_q == `PCL_SRC_CODE_RTC) ? PCL_SRC_RTC : PCL_SRC_CRYSTAL_REFERENCE;

    logic cur_lvl;
    logic new_lvl;
    always_comb begin
        case (src_q)
            PCL_SRC_LOOP: cur_lvl = osc_in;
            PCL_SRC_RTC:  cur_lvl = rtc_ref;
            default:      cur_lvl = crystal_reference;
        endcase
        case (want_src)
            PCL_SRC_LOOP: new_lvl = osc_in;
            PCL_SRC_RTC:  new_lvl = rtc_ref;
            default:      new_lvl = crystal_reference;
        endcase
    end

    // Swapping only while both sources sit low avoids a runt pulse on the system clock.
    wire do_swap = (want_src != src_q) & ~cur_lvl & ~new_lvl;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            src_q  <= PCL_SRC_CRYSTAL_REFERENCE;
            sclk_q <= 1'b0;
        end else begin
            if (do_swap) begin
                src_q  <= want_src;
                sclk_q <= new_lvl;
            end else begin
                sclk_q <= cur_lvl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    wire [7:0] ctl0_rd = {pump_q, 2'b00, crit_q, src_req_q};
    wire [7:0] ctl1_rd = {6'h00, lock_sync_q, en_q};
    wire [7:0] rd_mux  = hit_ctl0 ? ctl0_rd :
                         hit_ctl1 ? ctl1_rd :
                         hit_stat ? {6'h00, stat_q} :
                         hit_mask ? {6'h00, mask_q} : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata     = rdata_q;
    assign loop_enable   = en_q;
    assign pump_strength = pump_q;
    assign pump_up       = up_q;
    assign pump_dn       = dn_q;
    assign sclk_out      = sclk_q;
    assign sclk_src      = src_q;
endmodule // pcl_top

// ===== verification/pcl_monitor.sv
// Port-level concurrent checks of the loop clock block, bound into its top.
`timescale 1ns/1ps
`include "pcl_defs.svh"
module pcl_monitor (
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    // Register port
    input wire logic [`PCL_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    // Clock source levels
    input wire logic                   crystal_reference,
    input wire logic                   osc_in,
    input wire logic                   rtc_ref,
    // Analog controls
    input wire logic                   loop_enable,
    input wire logic [1:0]             pump_strength,
    input wire logic                   pump_up,
    input wire logic                   pump_dn,
    // System clock and interrupt
    input wire logic                   sclk_out,
    input wire pcl_pkg::pcl_src_e      sclk_src,
    input wire logic                   irq
);
    import pcl_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    reset_vals_a: assert property (
        $past(!rst_n) |-> sclk_src == PCL_SRC_CRYSTAL_REFERENCE && !loop_enable && !irq)
        else $error("outputs not at reset values");
    enable_wr_a: assert property (
        reg_wr && reg_addr == `PCL_ADDR_CTL1 |=> loop_enable == $past(reg_wdata[0]))
        else $error("loop enable does not follow write");
    // Leaving the loop source waits for a low slot, so only the move onto it is gated.
    loop_gate_a: assert property (
        $changed(sclk_src) && sclk_src == PCL_SRC_LOOP |-> $past(loop_enable))
        else $error("loop source taken while loop disabled");
    swap_low_a: assert property (
        sclk_src != $past(sclk_src) |-> !sclk_out)
        else $error("source swapped on a high level");
    src_onehot_a: assert property ($onehot(sclk_src))
        else $error("source select not one-hot");
    pump_idle_a: assert property (
        (!loop_enable)[*3] |-> !pump_up && !pump_dn)
        else $error("pump command while loop disabled");
    pump_wr_a: assert property (
        reg_wr && reg_addr == `PCL_ADDR_CTL0 && !loop_enable
        |=> pump_strength == $past(reg_wdata[7:6]))
        else $error("pump strength does not follow write");
    pump_hold_a: assert property (
        loop_enable && $past(loop_enable) |-> $stable(pump_strength))
        else $error("pump strength changed while enabled");
    div_rd_zero_a: assert property (
        reg_rd && (reg_addr == `PCL_ADDR_DIV_LO || reg_addr == `PCL_ADDR_DIV_HI)
        |=> reg_rdata == 8'h00)
        else $error("divider read not zero");
    irq_mask_a: assert property (
        reg_wr && reg_addr == `PCL_ADDR_MASK && reg_wdata == 8'h00 |=> !irq)
        else $error("interrupt high with all masked");

    ////////////////////////////////////////////////////////////////////////////////
    cover property (sclk_src == PCL_SRC_LOOP);
    cover property (sclk_src == PCL_SRC_RTC);
    cover property ($rose(irq));
endmodule // pcl_monitor

bind pcl_top pcl_monitor pcl_monitor_i (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .crystal_reference, .osc_in, .rtc_ref, .loop_enable, .pump_strength,
    .pump_up, .pump_dn, .sclk_out, .sclk_src, .irq
);

// ===== verification/testbench.sv
// Self-checking bench of the loop clock block over its register port.
`timescale 1ns/1ps
`include "pcl_defs.svh"
module testbench;
    import pcl_pkg::*;
    logic                   clk_sys = 1'b0;
    logic                   rst_n = 1'b0;
    logic [`PCL_ADDR_W-1:0] reg_addr = 8'h00;
    logic [7:0]             reg_wdata = 8'h00;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [7:0]             reg_rdata;
    logic                   crystal_reference = 1'b0;
    logic                   osc_in = 1'b0;
    logic                   rtc_ref = 1'b0;
    logic                   loop_enable;
    logic [1:0]             pump_strength;
    logic                   pump_up;
    logic                   pump_dn;
    logic                   sclk_out;
    pcl_src_e               sclk_src;
    logic                   irq;
    int                     error_cnt = 0;
    int                     n_checks = 0;
    int                     cyc = 0;
    int                     ph = 0;
    int                     skew = 0;
    int                     osc_per = 12;
    logic [7:0]             d;
    logic                   ok;

    pcl_top pcl_top_i (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .crystal_reference, .osc_in, .rtc_ref, .loop_enable, .pump_strength,
        .pump_up, .pump_dn, .sclk_out, .sclk_src, .irq
    );

    always #25 clk_sys = ~clk_sys;

    // Reference period is 24 cycles; the oscillator is an exact multiple of it, and skew
    // shifts the reference phase because the divider's own phase is not visible.
    always @(posedge clk_sys) begin
        ph <= (ph == 23) ? 0 : ph + 1;
        crystal_reference <= ((ph + skew) % 24) < 12;
        osc_in <= (ph % osc_per) < (osc_per / 2);
        rtc_ref <= (ph % 6) < 3;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic wait_src(input pcl_src_e s);
        int k;
        k = 0;
        while (sclk_src !== s && k < 200) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk("sclk_src", 8'(sclk_src), 8'(s));
    endtask

    // Sweeps the reference phase until the lock bit reads high, polling every ten cycles.
    task automatic wait_lock(output logic got);
        got = 1'b0;
        for (int s = 0; s < 24 && !got; s += 4) begin
            skew = s;
            for (int p = 0; p < 60 && !got; p++) begin
                repeat (8) @(posedge clk_sys);
                rd(`PCL_ADDR_CTL1, d);
                got = (d[`PCL_CTL1_LOCK_BIT] === 1'b1);
            end
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        wr(8'h70, 8'hFF);
        for (int a = 'h5C; a <= 'h62; a++) begin
            rd(8'(a), d);
            chk("reset read", d, 8'h00);
        end
        chk("sclk_src", 8'(sclk_src), 8'(PCL_SRC_CRYSTAL_REFERENCE));
        chk("loop_enable", 8'(loop_enable), 8'h00);
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            wr(`PCL_ADDR_CTL0, 8'(i << 6));
            chk("pump_strength", 8'(pump_strength), 8'(i));
            rd(`PCL_ADDR_CTL0, d);
            chk("ctl0", d, 8'(i << 6));
        end
        wr(`PCL_ADDR_CTL0, 8'h02);
        wr(`PCL_ADDR_CTL0, 8'h03);
        rd(`PCL_ADDR_CTL0, d);
        chk("ctl0 keep", d, 8'h02);
        wait_src(PCL_SRC_RTC);
        wr(`PCL_ADDR_CTL0, 8'h08);
        wait_src(PCL_SRC_CRYSTAL_REFERENCE);
        $display("test source select done");

        // Divider one becomes two; the later low byte stays pending without a high write.
        wr(`PCL_ADDR_DIV_LO, 8'h01);
        wr(`PCL_ADDR_DIV_HI, 8'h00);
        wr(`PCL_ADDR_DIV_LO, 8'h03);
        wr(`PCL_ADDR_MASK, 8'h01);
        wr(`PCL_ADDR_CTL1, 8'h01);
        chk("loop_enable", 8'(loop_enable), 8'h01);
        wr(`PCL_ADDR_CTL0, 8'hC9);
        rd(`PCL_ADDR_CTL0, d);
        chk("ctl0 while enabled", d, 8'h09);
        chk("sclk_src", 8'(sclk_src), 8'(PCL_SRC_CRYSTAL_REFERENCE));
        wait_lock(ok);
        chk("lock at two", 8'(ok), 8'h01);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("irq", 8'(irq), 8'h01);
        wait_src(PCL_SRC_LOOP);
        rd(`PCL_ADDR_STAT, d);
        chk("status", d, 8'h01);
        chk("irq cleared", 8'(irq), 8'h00);
        $display("test lock and switch done");

        wr(`PCL_ADDR_CTL1, 8'h00);
        wait_src(PCL_SRC_CRYSTAL_REFERENCE);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("irq masked", 8'(irq), 8'h00);
        rd(`PCL_ADDR_STAT, d);
        chk("status", d, 8'h02);
        $display("test disable done");

        // Loading the pending byte gives three, so the ratio-two oscillator must not lock.
        wr(`PCL_ADDR_DIV_HI, 8'h00);
        wr(`PCL_ADDR_CTL0, 8'h0D);
        wr(`PCL_ADDR_MASK, 8'h00);
        wr(`PCL_ADDR_CTL1, 8'h01);
        wait_lock(ok);
        chk("lock wrong ratio", 8'(ok), 8'h00);
        osc_per = 8;
        wait_lock(ok);
        chk("lock at three", 8'(ok), 8'h01);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("irq masked", 8'(irq), 8'h00);
        wr(`PCL_ADDR_MASK, 8'h01);
        chk("irq unmasked", 8'(irq), 8'h01);
        wait_src(PCL_SRC_LOOP);
        rd(`PCL_ADDR_STAT, d);
        chk("status", d, 8'h01);
        $display("test ratio three done");
        conclude();
    end
endmodule // testbench
